// *** dma_irq_status_clear.sv ***
// Interrupt status and transfer-end clear registers of a two-channel DMA
//
// Overview of operation
// R1: Transfer-end status has bit n for channel n, 1 when interrupt requested.
// R2: Transfer-end status bits are the raw flags gated by their enables.
// R3: Writing 1 to a clear bit clears that flag; 0 leaves it alone. Here a transfer end in the same cycle wins over the clear.
// R4: Error status has bit n for channel n, 1 when error interrupt requested.
// R5: Error status bits are raw errors gated by their error enables.
// R6: Channel interrupt is enabled transfer-end or enabled error.
// R7: A raw transfer-end flag per channel is kept before the enable.
// R8: Software writes zero above bit 1; device ignores those bits. Here the event mask write keeps bits 3:2 as well.
`timescale 1ns/100ps
module dma_irq_status_clear (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire dma_irq_pkg::bus_req_s          bus_req,
  output logic      [dma_irq_pkg::DATA_W-1:0] rdata,
  input  wire dma_irq_pkg::chan_in_s          chan_in,
  output dma_irq_pkg::chan_vec_t              chan_irq,
  output logic                                irq
);
  function automatic logic hit(
    input logic [dma_irq_pkg::ADDR_W-1:0] addr,
    input logic [dma_irq_pkg::ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  dma_irq_pkg::chan_vec_t          raw_tc;
  dma_irq_pkg::chan_vec_t          tc_status;
  dma_irq_pkg::chan_vec_t          err_status;
  dma_irq_pkg::chan_vec_t          tc_clear_vec;
  dma_irq_pkg::chan_vec_t          err_prev;
  dma_irq_pkg::chan_vec_t          next_err_prev;
  logic [dma_irq_pkg::EVT_W-1:0]   evt;
  logic [dma_irq_pkg::EVT_W-1:0]   evt_status;
  logic [dma_irq_pkg::EVT_W-1:0]   evt_mask;
  logic [dma_irq_pkg::DATA_W-1:0]  next_rdata;
  logic                            wr_tc_clear;
  logic                            wr_evt_mask;
  logic                            rd_evt_status;

  // Write and event-status read decode
  always_comb begin
    wr_tc_clear   = 1'b0;
    wr_evt_mask   = 1'b0;
    rd_evt_status = 1'b0;
    if (bus_req.wr && hit(bus_req.addr, dma_irq_pkg::OFS_TC_CLEAR)) begin
      wr_tc_clear = 1'b1;
    end else if (bus_req.wr &&
                 hit(bus_req.addr, dma_irq_pkg::OFS_EVT_MASK)) begin
      wr_evt_mask = 1'b1;
    end else if (bus_req.rd &&
                 hit(bus_req.addr, dma_irq_pkg::OFS_EVT_STATUS)) begin
      rd_evt_status = 1'b1;
    end
  end

  a_decode_once: assert property (@(posedge clk)
    disable iff (!reset_n)
    $onehot0({wr_tc_clear, wr_evt_mask, rd_evt_status}))
    else $error("more than one register strobe decoded");

  // Upper write bits are dropped
  assign tc_clear_vec = wr_tc_clear ?
                        bus_req.wdata[dma_irq_pkg::NUM_CH-1:0] :
                        dma_irq_pkg::RESET_FLAGS; // R3 R8

  genvar ch;
  generate
    for (ch = 0; ch < dma_irq_pkg::NUM_CH; ch++) begin : g_ch
      end_flag u_end_flag (
        .clk     (clk),
        .reset_n (reset_n),
        .set     (chan_in.tc_done[ch]),
        .clear   (tc_clear_vec[ch]),
        .flag    (raw_tc[ch])
      ); // R7 R3

      // Flag rises only on a transfer end, falls only on a written one
      a_raw_rise: assert property (@(posedge clk) // R7
        disable iff (!reset_n)
        (!raw_tc[ch] && !chan_in.tc_done[ch]) |=> !raw_tc[ch])
        else $error("raw flag rose without transfer end");
      a_clear_zero: assert property (@(posedge clk) // R3
        disable iff (!reset_n)
        (raw_tc[ch] && !tc_clear_vec[ch]) |=> raw_tc[ch])
        else $error("flag dropped without a written one");
      a_set_wins: assert property (@(posedge clk) // R3
        disable iff (!reset_n)
        (tc_clear_vec[ch] && chan_in.tc_done[ch]) |=> raw_tc[ch])
        else $error("clear beat a transfer end");
      a_clear_one: assert property (@(posedge clk) // R3
        disable iff (!reset_n)
        (tc_clear_vec[ch] && !chan_in.tc_done[ch]) |=> !raw_tc[ch])
        else $error("written one did not clear flag");
      a_tc_gate: assert property (@(posedge clk) // R2
        disable iff (!reset_n)
        tc_status[ch] == (raw_tc[ch] && chan_in.tc_en[ch]))
        else $error("transfer-end status not gated");
      a_err_gate: assert property (@(posedge clk) // R5
        disable iff (!reset_n)
        err_status[ch] == (chan_in.err_raw[ch] && chan_in.err_en[ch]))
        else $error("error status not gated");
    end
  endgenerate

  assign tc_status  = raw_tc & chan_in.tc_en;          // R1 R2
  assign err_status = chan_in.err_raw & chan_in.err_en; // R4 R5
  assign chan_irq   = tc_status | err_status;           // R6

  // A channel with neither source enabled never requests
  a_chan_quiet: assert property (@(posedge clk) // R6
    disable iff (!reset_n)
    (!chan_in.tc_en[0] && !chan_in.err_en[0]) |-> !chan_irq[0])
    else $error("channel 0 requests with both enables low");

  // Events: enabled transfer end or rising enabled error
  always_comb begin
    next_err_prev = err_status;
    evt = dma_irq_pkg::RESET_EVT;
    evt[dma_irq_pkg::EVT_TC_LSB +: dma_irq_pkg::NUM_CH] =
      chan_in.tc_done & chan_in.tc_en;
    evt[dma_irq_pkg::EVT_ERR_LSB +: dma_irq_pkg::NUM_CH] =
      err_status & ~err_prev;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_prev <= dma_irq_pkg::RESET_FLAGS;
    end else begin
      err_prev <= next_err_prev;
    end
  end

  event_irq u_event_irq (
    .clk        (clk),
    .reset_n    (reset_n),
    .evt        (evt),
    .rd_clear   (rd_evt_status),
    .mask_wr    (wr_evt_mask),
    .mask_wdata (bus_req.wdata[dma_irq_pkg::EVT_W-1:0]),
    .status     (evt_status),
    .mask       (evt_mask),
    .irq        (irq)
  );

  // Sticky events: set on an event, kept until the status is read
  a_evt_set: assert property (@(posedge clk)
    disable iff (!reset_n)
    (evt != dma_irq_pkg::RESET_EVT) |=>
      ((evt_status & $past(evt)) == $past(evt)))
    else $error("event did not set its status bit");
  a_evt_sticky: assert property (@(posedge clk)
    disable iff (!reset_n)
    !rd_evt_status |=>
      ((evt_status & $past(evt_status)) == $past(evt_status)))
    else $error("event status dropped without a read");
  a_evt_clear: assert property (@(posedge clk)
    disable iff (!reset_n)
    (rd_evt_status && (evt == dma_irq_pkg::RESET_EVT)) |=>
      (evt_status == dma_irq_pkg::RESET_EVT))
    else $error("event status read did not clear");
  a_err_edge: assert property (@(posedge clk)
    disable iff (!reset_n)
    (err_status[0] && !$past(err_status[0])) |->
      evt[dma_irq_pkg::EVT_ERR_LSB])
    else $error("rising error gave no event");
  a_mask_write: assert property (@(posedge clk)
    disable iff (!reset_n)
    wr_evt_mask |=>
      (evt_mask == $past(bus_req.wdata[dma_irq_pkg::EVT_W-1:0])))
    else $error("event mask write lost");
  a_mask_hold: assert property (@(posedge clk)
    disable iff (!reset_n)
    !wr_evt_mask |=> $stable(evt_mask))
    else $error("event mask changed without a write");
  a_irq_quiet: assert property (@(posedge clk)
    disable iff (!reset_n)
    ((evt_status & evt_mask) == dma_irq_pkg::RESET_EVT) |-> !irq)
    else $error("interrupt high with no unmasked event");

  // Read mux; unused upper bits and unmapped addresses read zero
  always_comb begin
    next_rdata = dma_irq_pkg::RESET_RDATA;
    if (bus_req.rd) begin
      if (hit(bus_req.addr, dma_irq_pkg::OFS_INT_STATUS)) begin
        next_rdata[dma_irq_pkg::NUM_CH-1:0] = chan_irq; // R6
      end else if (hit(bus_req.addr, dma_irq_pkg::OFS_TC_STATUS)) begin
        next_rdata[dma_irq_pkg::NUM_CH-1:0] = tc_status; // R1
      end else if (hit(bus_req.addr, dma_irq_pkg::OFS_ERR_STATUS)) begin
        next_rdata[dma_irq_pkg::NUM_CH-1:0] = err_status; // R4
      end else if (hit(bus_req.addr, dma_irq_pkg::OFS_RAW_TC)) begin
        next_rdata[dma_irq_pkg::NUM_CH-1:0] = raw_tc; // R7
      end else if (hit(bus_req.addr, dma_irq_pkg::OFS_RAW_ERR)) begin
        next_rdata[dma_irq_pkg::NUM_CH-1:0] = chan_in.err_raw;
      end else if (hit(bus_req.addr, dma_irq_pkg::OFS_EVT_STATUS)) begin
        next_rdata[dma_irq_pkg::EVT_W-1:0] = evt_status;
      end else if (hit(bus_req.addr, dma_irq_pkg::OFS_EVT_MASK)) begin
        next_rdata[dma_irq_pkg::EVT_W-1:0] = evt_mask;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= dma_irq_pkg::RESET_RDATA;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Read data stand one cycle after the strobe, then fall back to zero
  a_rdata_idle: assert property (@(posedge clk)
    disable iff (!reset_n)
    !bus_req.rd |=> (rdata == dma_irq_pkg::RESET_RDATA))
    else $error("read data not zero outside a read");
  a_int_read: assert property (@(posedge clk) // R6
    disable iff (!reset_n)
    (bus_req.rd && hit(bus_req.addr, dma_irq_pkg::OFS_INT_STATUS)) |=>
      (rdata[dma_irq_pkg::NUM_CH-1:0] == $past(chan_irq)))
    else $error("combined status read mismatch");
  a_raw_tc_read: assert property (@(posedge clk) // R7
    disable iff (!reset_n)
    (bus_req.rd && hit(bus_req.addr, dma_irq_pkg::OFS_RAW_TC)) |=>
      (rdata[dma_irq_pkg::NUM_CH-1:0] == $past(raw_tc)))
    else $error("raw transfer-end read mismatch");
  a_raw_err_read: assert property (@(posedge clk)
    disable iff (!reset_n)
    (bus_req.rd && hit(bus_req.addr, dma_irq_pkg::OFS_RAW_ERR)) |=>
      (rdata[dma_irq_pkg::NUM_CH-1:0] == $past(chan_in.err_raw)))
    else $error("raw error read mismatch");
  a_evt_read: assert property (@(posedge clk)
    disable iff (!reset_n)
    rd_evt_status |=>
      (rdata[dma_irq_pkg::EVT_W-1:0] == $past(evt_status)))
    else $error("event status read mismatch");
  a_mask_read: assert property (@(posedge clk)
    disable iff (!reset_n)
    (bus_req.rd && hit(bus_req.addr, dma_irq_pkg::OFS_EVT_MASK)) |=>
      (rdata[dma_irq_pkg::EVT_W-1:0] == $past(evt_mask)))
    else $error("event mask read mismatch");

  // Checks
  a_tc_bit_map: assert property (@(posedge clk) // R1
    disable iff (!reset_n)
    (bus_req.rd && hit(bus_req.addr, dma_irq_pkg::OFS_TC_STATUS)) |=>
      (rdata[dma_irq_pkg::NUM_CH-1:0] ==
       ($past(raw_tc) & $past(chan_in.tc_en))))
    else $error("transfer-end status read mismatch");
  a_tc_masked: assert property (@(posedge clk) // R2
    disable iff (!reset_n)
    (|(chan_in.tc_done & chan_in.tc_en)) |=>
      ((tc_status & $past(chan_in.tc_done) & chan_in.tc_en) ==
       ($past(chan_in.tc_done) & chan_in.tc_en)))
    else $error("enabled transfer end not shown in status");
  a_tc_clear_one: assert property (@(posedge clk) // R3
    disable iff (!reset_n)
    wr_tc_clear |=>
      ((raw_tc & $past(bus_req.wdata[dma_irq_pkg::NUM_CH-1:0])
        & ~$past(chan_in.tc_done)) == dma_irq_pkg::RESET_FLAGS))
    else $error("written clear bit did not clear flag");
  a_tc_clear_zero: assert property (@(posedge clk) // R3
    disable iff (!reset_n)
    (wr_tc_clear && !bus_req.wdata[0] && raw_tc[0]) |=> raw_tc[0])
    else $error("zero clear bit changed flag");
  a_err_bit_map: assert property (@(posedge clk) // R4 R5
    disable iff (!reset_n)
    (bus_req.rd && hit(bus_req.addr, dma_irq_pkg::OFS_ERR_STATUS)) |=>
      (rdata[dma_irq_pkg::NUM_CH-1:0] ==
       ($past(chan_in.err_raw) & $past(chan_in.err_en))))
    else $error("error status read mismatch");
  a_chan_irq_or: assert property (@(posedge clk) // R6
    disable iff (!reset_n)
    chan_irq == ((raw_tc & chan_in.tc_en) |
                 (chan_in.err_raw & chan_in.err_en)))
    else $error("channel interrupt not the enabled sources");
  a_raw_tc_set: assert property (@(posedge clk) // R7
    disable iff (!reset_n)
    (|chan_in.tc_done) |=>
      ((raw_tc & $past(chan_in.tc_done)) == $past(chan_in.tc_done)))
    else $error("transfer end did not set raw flag");
  a_raw_hold: assert property (@(posedge clk) // R7
    disable iff (!reset_n)
    (raw_tc[0] && !tc_clear_vec[0]) |=> raw_tc[0])
    else $error("raw flag dropped without clear");
  a_upper_zero: assert property (@(posedge clk) // R8
    disable iff (!reset_n)
    bus_req.rd |=> (rdata[dma_irq_pkg::DATA_W-1:dma_irq_pkg::EVT_W] == '0))
    else $error("upper read bits not zero");
  a_irq_level: assert property (@(posedge clk)
    disable iff (!reset_n)
    (evt != dma_irq_pkg::RESET_EVT) |=> irq ||
      ((evt_mask & $past(evt)) == dma_irq_pkg::RESET_EVT))
    else $error("unmasked event did not raise interrupt");
endmodule

// *** dma_irq_pkg.sv ***
// Shared constants and carrier types for the DMA interrupt status block
package dma_irq_pkg;
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int EVT_W  = 4;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_TC_STATUS  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_TC_CLEAR   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ERR_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_RAW_TC     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_RAW_ERR    = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 12'h044;

  // Event register layout
  localparam int EVT_TC_LSB  = 0;
  localparam int EVT_ERR_LSB = 2;

  // Reset values
  localparam logic [NUM_CH-1:0] RESET_FLAGS = 2'h0;
  localparam logic [EVT_W-1:0]  RESET_EVT   = 4'h0;
  localparam logic [DATA_W-1:0] RESET_RDATA = 32'h0;

  typedef logic [NUM_CH-1:0] chan_vec_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef struct packed {
    chan_vec_t tc_done;
    chan_vec_t err_raw;
    chan_vec_t tc_en;
    chan_vec_t err_en;
  } chan_in_s;
endpackage

// *** end_flag.sv ***
// Per-channel raw transfer-end flag, set wins over clear
`timescale 1ns/100ps
module end_flag (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  logic next_flag;

  always_comb begin
    next_flag = set | (flag & ~clear);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule

// *** event_irq.sv ***
// Sticky event status, mask and level interrupt output
`timescale 1ns/100ps
module event_irq (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [dma_irq_pkg::EVT_W-1:0] evt,
  input  wire logic                          rd_clear,
  input  wire logic                          mask_wr,
  input  wire logic [dma_irq_pkg::EVT_W-1:0] mask_wdata,
  output logic      [dma_irq_pkg::EVT_W-1:0] status,
  output logic      [dma_irq_pkg::EVT_W-1:0] mask,
  output logic                               irq
);
  logic [dma_irq_pkg::EVT_W-1:0] next_status;
  logic [dma_irq_pkg::EVT_W-1:0] next_mask;

  always_comb begin
    next_status = evt | (rd_clear ? dma_irq_pkg::RESET_EVT : status);
    next_mask   = mask_wr ? mask_wdata : mask;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= dma_irq_pkg::RESET_EVT;
      mask   <= dma_irq_pkg::RESET_EVT;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  assign irq = |(status & mask);
endmodule

// *** dma_irq_status_clear_tb_top.sv ***
// Self-checking testbench for the DMA interrupt status and clear block
`timescale 1ns/100ps
module dma_irq_status_clear_tb_top;
  logic                   clk       = 1'b0;
  logic                   reset_n   = 1'b0;
  dma_irq_pkg::bus_req_s  bus_req   = '0;
  dma_irq_pkg::chan_in_s  chan_in   = '0;
  logic [31:0]            rdata;
  dma_irq_pkg::chan_vec_t chan_irq;
  logic                   irq;
  int                     fails     = 0;
  int                     tests_run = 0;

  always #25 clk = ~clk;

  dma_irq_status_clear dut_u (
    .clk      (clk),
    .reset_n  (reset_n),
    .bus_req  (bus_req),
    .rdata    (rdata),
    .chan_in  (chan_in),
    .chan_irq (chan_irq),
    .irq      (irq)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  task automatic drive(logic [1:0] done, logic [1:0] err,
                       logic [1:0] tc_en, logic [1:0] err_en);
    @(posedge clk);
    chan_in <= '{tc_done: done, err_raw: err, tc_en: tc_en, err_en: err_en};
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check("irq after reset", {31'h0, irq}, 32'h0);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h0);
    rd_chk("err status", dma_irq_pkg::OFS_ERR_STATUS, 32'h0);
    wr(dma_irq_pkg::OFS_EVT_MASK, 32'h0000000F);
    // Transfer end on channel 0
    drive(2'h1, 2'h0, 2'h3, 2'h0);
    drive(2'h0, 2'h0, 2'h3, 2'h0);
    #1;
    check("chan_irq", {30'h0, chan_irq}, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk("int status", dma_irq_pkg::OFS_INT_STATUS, 32'h1);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h1);
    rd_chk("raw tc", dma_irq_pkg::OFS_RAW_TC, 32'h1);
    // Channel 1 ends, then its enable is dropped
    drive(2'h2, 2'h0, 2'h3, 2'h0);
    drive(2'h0, 2'h0, 2'h1, 2'h0);
    #1;
    check("chan_irq masked", {30'h0, chan_irq}, 32'h1);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h1);
    rd_chk("raw tc", dma_irq_pkg::OFS_RAW_TC, 32'h3);
    drive(2'h0, 2'h0, 2'h3, 2'h0);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h3);
    // Zero bits of the clear must do nothing
    wr(dma_irq_pkg::OFS_TC_CLEAR, 32'h00000000);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h3);
    wr(dma_irq_pkg::OFS_TC_STATUS, 32'h00000000);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h3);
    wr(dma_irq_pkg::OFS_TC_CLEAR, 32'h00000002);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h1);
    wr(dma_irq_pkg::OFS_TC_CLEAR, 32'h00000001);
    rd_chk("tc status", dma_irq_pkg::OFS_TC_STATUS, 32'h0);
    rd_chk("raw tc", dma_irq_pkg::OFS_RAW_TC, 32'h0);
    // Clear and transfer end in one cycle: the end wins
    fork
      wr(dma_irq_pkg::OFS_TC_CLEAR, 32'h00000001);
      begin
        drive(2'h1, 2'h0, 2'h3, 2'h0);
        drive(2'h0, 2'h0, 2'h3, 2'h0);
      end
    join
    rd_chk("raw tc", dma_irq_pkg::OFS_RAW_TC, 32'h1);
    wr(dma_irq_pkg::OFS_TC_CLEAR, 32'h00000001);
    rd_chk("raw tc", dma_irq_pkg::OFS_RAW_TC, 32'h0);
    // Sticky events, cleared by reading
    rd_chk("event status", dma_irq_pkg::OFS_EVT_STATUS, 32'h3);
    #1;
    check("irq after read", {31'h0, irq}, 32'h0);
    // Masked error event keeps the output low
    wr(dma_irq_pkg::OFS_EVT_MASK, 32'h00000000);
    drive(2'h0, 2'h1, 2'h0, 2'h1);
    repeat (2) @(posedge clk);
    #1;
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(dma_irq_pkg::OFS_EVT_MASK, 32'h00000004);
    #1;
    check("irq unmasked", {31'h0, irq}, 32'h1);
    rd_chk("event mask", dma_irq_pkg::OFS_EVT_MASK, 32'h4);
    rd_chk("event status", dma_irq_pkg::OFS_EVT_STATUS, 32'h4);
    // Every error and enable combination
    for (int i = 0; i < 16; i++) begin
      drive(2'h0, i[1:0], 2'h0, i[3:2]);
      #1;
      check("chan_irq err", {30'h0, chan_irq}, {30'h0, i[1:0] & i[3:2]});
      rd_chk("err status", dma_irq_pkg::OFS_ERR_STATUS,
             {30'h0, i[1:0] & i[3:2]});
      rd_chk("int status", dma_irq_pkg::OFS_INT_STATUS,
             {30'h0, i[1:0] & i[3:2]});
      rd_chk("raw err", dma_irq_pkg::OFS_RAW_ERR, {30'h0, i[1:0]});
    end
    rd_chk("unmapped", 12'h0FC, 32'h0);
    end_of_test();
  end
endmodule
